// ===== common/dsadc_defs.svh
// Register indices, field positions, reset values and timing constants.
`ifndef DSADC_DEFS_SVH
`define DSADC_DEFS_SVH

// Register indices; the byte address is four times the index.
`define DSADC_IDX_CTLA 16'hff7c
`define DSADC_IDX_CTLB 16'hff7d
`define DSADC_IDX_RES_WIDE 16'hff7e
`define DSADC_IDX_RES_HIGH 16'hff7f
`define DSADC_IDX_STATUS 16'hff80
`define DSADC_IDX_PIN_CFG 16'hff81
`define DSADC_IDX_PIN_DIR 16'hff82
`define DSADC_IDX_PORT_DATA 16'hff83

// First control register fields.
`define DSADC_A_POWER 7
`define DSADC_A_ENABLE 6
`define DSADC_A_HAC 5
`define DSADC_A_MODE 4
`define DSADC_A_CHAN_HI 1
`define DSADC_A_CHAN_LO 0
`define DSADC_A_MASK 8'hf3

// Second control register fields.
`define DSADC_B_CLK_HI 7
`define DSADC_B_CLK_LO 6
`define DSADC_B_TS 5
`define DSADC_B_N_HI 2
`define DSADC_B_N_LO 0
`define DSADC_B_MASK 8'he7

// Status register fields.
`define DSADC_S_COLLIDE 4
`define DSADC_S_CHAN_HI 1
`define DSADC_S_CHAN_LO 0

// Reset values.
`define DSADC_RST_BYTE 8'h00
`define DSADC_RST_DIR 8'hff

// Channel that may not be selected.
`define DSADC_CHAN_BAD 2'h3

// Sampling count: 256 for code 0, otherwise 2 to the power code plus 9.
`define DSADC_LOG2_N_MIN 5'h08
`define DSADC_LOG2_N_OFS 5'h09
`define DSADC_RES_BITS 5'h10

// Sampling clock dividers of the peripheral clock.
`define DSADC_DIV4 5'h03
`define DSADC_DIV8 5'h07
`define DSADC_DIV16 5'h0f

`endif

// ===== common/dsadc_pkg.sv
// Shared types of the delta-sigma converter control block.
package dsadc_pkg;

  typedef logic [31:0] dsadc_word_t;
  typedef logic [15:0] dsadc_result_t;
  typedef logic [1:0] dsadc_chan_t;

  typedef enum logic [1:0] {
    DSADC_CLK_DIV4,
    DSADC_CLK_DIV8,
    DSADC_CLK_DIV16,
    DSADC_CLK_SUB2
  } dsadc_clk_sel_t;

endpackage : dsadc_pkg

// ===== logic/dsadc_decimator.sv
// Counts modulator ones over N samples and yields an aligned result.
`timescale 1ns/10ps
`include "dsadc_defs.svh"

module dsadc_decimator (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control.
  input wire logic restart,
  input wire logic run,
  input wire logic tick,
  input wire logic mod_bit,
  input wire logic [4:0] log2_n,
  // Result.
  output dsadc_pkg::dsadc_result_t result,
  output logic done
);
  import dsadc_pkg::*;

  logic [16:0] samp_cnt;
  logic [16:0] ones_cnt;
  logic [16:0] last_samp;
  logic [16:0] next_sum;
  logic [31:0] scaled;

  always_comb begin
    last_samp = 17'((32'h1 << log2_n) - 32'h1);
    next_sum = ones_cnt + {16'h0, mod_bit};
    scaled = {15'h0, next_sum} << (`DSADC_RES_BITS - log2_n);
  end

  // A full-scale count would need a seventeenth bit, so it saturates.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt <= 17'h0;
      ones_cnt <= 17'h0;
      result <= 16'h0;
      done <= 1'b0;
    end else if (!run || restart) begin
      samp_cnt <= 17'h0;
      ones_cnt <= 17'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        if (samp_cnt == last_samp) begin
          result <= (scaled > 32'hffff) ? 16'hffff : scaled[15:0];
          samp_cnt <= 17'h0;
          ones_cnt <= 17'h0;
          done <= 1'b1;
        end else begin
          samp_cnt <= samp_cnt + 17'h1;
          ones_cnt <= next_sum;
        end
      end
    end
  end

endmodule : dsadc_decimator

// ===== logic/dsadc_ctrl.sv
// Delta-sigma converter control with AHB-Lite register slave.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
`include "dsadc_defs.svh"

// Function
// - Convert selected channel repeatedly while powered and enabled.
// - Load result first, then raise interrupt.
// - Fewer result bits shorten each conversion.
// - Wide result holds value in upper bits.
// - High byte register gets top eight bits.
// - Result register reads insert one wait.
// - Unselected pins remain general-purpose port pins unless set analog in pin config.
// - Differential or single-ended positive-pin input mode.
// - Control logic starts, stops and times conversion.
// - Control A: power, enable, accuracy, mode, channel.
// - Control B: clock, serial/parallel, sampling count.
// - Status records channel on each completion, flags completion-change coincidence.
// - Pin config selects analog or digital, direction.
// - Any control A write reinitializes converter.
// - Sampling count codes 256 through 65536.
module dsadc_ctrl (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire dsadc_pkg::dsadc_word_t hwdata,
  input wire logic hready,
  output logic hreadyout,
  output dsadc_pkg::dsadc_word_t hrdata,
  output logic hresp,
  // Modulator and clock inputs from outside.
  input wire logic mod_bit_in,
  input wire logic sub_clk_in,
  // Analog front-end controls.
  output logic ana_power_on,
  output logic ana_high_accuracy,
  output logic ana_differential,
  output dsadc_pkg::dsadc_chan_t ana_chan,
  output logic ana_parallel,
  output logic ana_sample_clk,
  // Shared port pins.
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  output logic [7:0] port_analog,
  // Interrupt request.
  output logic conv_done_irq
);
  import dsadc_pkg::*;

  // Pins used by a pair: even pin negative, odd pin positive.
  function automatic logic [7:0] pair_mask(input dsadc_chan_t ch);
    pair_mask = 8'h03 << {ch, 1'b0};
  endfunction : pair_mask

  function automatic logic [4:0] log2_of_code(input logic [2:0] code);
    log2_of_code = (code == 3'h0) ? `DSADC_LOG2_N_MIN :
                   5'(code) + `DSADC_LOG2_N_OFS;
  endfunction : log2_of_code

  // Software-visible registers.
  logic [7:0] conv_control_a;
  logic [7:0] conv_control_b;
  logic [31:0] result_wide;
  logic [7:0] result_high_byte;
  logic [7:0] conv_channel_status;
  logic [7:0] pin_analog_config;
  logic [7:0] pin_direction_cfg;
  logic [7:0] port_data;

  // Named control fields.
  logic converter_power_on;
  logic conversion_enable;
  logic high_accuracy_en;
  logic input_mode_sel;
  dsadc_chan_t chan_sel;
  dsadc_clk_sel_t clk_sel;
  logic serial_parallel_sel;
  logic [2:0] sample_count_sel;

  always_comb begin
    converter_power_on = conv_control_a[`DSADC_A_POWER];
    conversion_enable = conv_control_a[`DSADC_A_ENABLE];
    high_accuracy_en = conv_control_a[`DSADC_A_HAC];
    input_mode_sel = conv_control_a[`DSADC_A_MODE];
    chan_sel = conv_control_a[`DSADC_A_CHAN_HI:`DSADC_A_CHAN_LO];
    clk_sel = dsadc_clk_sel_t'(
      conv_control_b[`DSADC_B_CLK_HI:`DSADC_B_CLK_LO]);
    serial_parallel_sel = conv_control_b[`DSADC_B_TS];
    sample_count_sel = conv_control_b[`DSADC_B_N_HI:`DSADC_B_N_LO];
  end

  // Bus address phase.
  logic accept;
  logic [15:0] addr_idx;
  logic addr_ok;
  logic wr_pend;
  logic [15:0] wr_idx;
  logic rd_wait;
  logic [15:0] rd_idx;

  always_comb begin
    accept = hsel && htrans[1] && hready;
    addr_idx = haddr[17:2];
    addr_ok = (haddr[31:18] == 14'h0) && (haddr[1:0] == 2'h0);
  end

  function automatic logic is_result(input logic [15:0] idx);
    is_result = (idx == `DSADC_IDX_RES_WIDE) ||
                (idx == `DSADC_IDX_RES_HIGH);
  endfunction : is_result

  // Synchronised external inputs.
  logic [1:0] mod_sync;
  logic [1:0] sub_sync;
  logic [7:0] port_meta;
  logic [7:0] port_sync;
  logic sub_prev;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_sync <= 2'h0;
      sub_sync <= 2'h0;
      sub_prev <= 1'b0;
      port_meta <= 8'h0;
      port_sync <= 8'h0;
    end else begin
      mod_sync <= {mod_sync[0], mod_bit_in};
      sub_sync <= {sub_sync[0], sub_clk_in};
      sub_prev <= sub_sync[1];
      port_meta <= port_in;
      port_sync <= port_meta;
    end
  end

  function automatic dsadc_word_t read_mux(input logic [15:0] idx);
    case (idx)
      `DSADC_IDX_CTLA: read_mux = {24'h0, conv_control_a};
      `DSADC_IDX_CTLB: read_mux = {24'h0, conv_control_b};
      `DSADC_IDX_RES_WIDE: read_mux = result_wide;
      `DSADC_IDX_RES_HIGH: read_mux = {24'h0, result_high_byte};
      `DSADC_IDX_STATUS: read_mux = {24'h0, conv_channel_status};
      `DSADC_IDX_PIN_CFG: read_mux = {24'h0, pin_analog_config};
      `DSADC_IDX_PIN_DIR: read_mux = {24'h0, pin_direction_cfg};
      `DSADC_IDX_PORT_DATA: read_mux = {24'h0, port_sync};
      default: read_mux = 32'h0;
    endcase
  endfunction : read_mux

  // Bus handshake and read data.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_idx <= 16'h0;
      rd_wait <= 1'b0;
      rd_idx <= 16'h0;
    end else begin
      hresp <= 1'b0;
      wr_pend <= accept && hwrite && addr_ok;
      if (accept) begin
        wr_idx <= addr_idx;
      end
      if (rd_wait) begin
        rd_wait <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= read_mux(rd_idx);
      end else if (accept && !hwrite && addr_ok && is_result(addr_idx)) begin
        rd_wait <= 1'b1;
        rd_idx <= addr_idx;
        hreadyout <= 1'b0;
      end else if (accept && !hwrite) begin
        hrdata <= addr_ok ? read_mux(addr_idx) : 32'h0;
      end
    end
  end

  // Register write strobes.
  logic wr_ctla;
  logic wr_ctlb;
  logic wr_status;

  always_comb begin
    wr_ctla = wr_pend && (wr_idx == `DSADC_IDX_CTLA);
    wr_ctlb = wr_pend && (wr_idx == `DSADC_IDX_CTLB);
    wr_status = wr_pend && (wr_idx == `DSADC_IDX_STATUS);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_control_a <= `DSADC_RST_BYTE;
    end else if (wr_ctla) begin
      conv_control_a <= hwdata[7:0] & `DSADC_A_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_control_b <= `DSADC_RST_BYTE;
    end else if (wr_ctlb) begin
      conv_control_b <= hwdata[7:0] & `DSADC_B_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_analog_config <= `DSADC_RST_BYTE;
      pin_direction_cfg <= `DSADC_RST_DIR;
      port_data <= `DSADC_RST_BYTE;
    end else if (wr_pend) begin
      if (wr_idx == `DSADC_IDX_PIN_CFG) begin
        pin_analog_config <= hwdata[7:0];
      end
      if (wr_idx == `DSADC_IDX_PIN_DIR) begin
        pin_direction_cfg <= hwdata[7:0];
      end
      if (wr_idx == `DSADC_IDX_PORT_DATA) begin
        port_data <= hwdata[7:0];
      end
    end
  end

  // Conversion run state.
  logic running;
  logic reinit;

  always_comb begin
    running = converter_power_on && conversion_enable &&
              (chan_sel != `DSADC_CHAN_BAD);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reinit <= 1'b0;
    end else begin
      reinit <= wr_ctla || wr_ctlb;
    end
  end

  // Sampling clock ticks.
  logic [4:0] div_cnt;
  logic [4:0] div_last;
  logic sub_half;
  logic samp_tick;

  always_comb begin
    case (clk_sel)
      DSADC_CLK_DIV4: div_last = `DSADC_DIV4;
      DSADC_CLK_DIV8: div_last = `DSADC_DIV8;
      DSADC_CLK_DIV16: div_last = `DSADC_DIV16;
      default: div_last = `DSADC_DIV4;
    endcase
  end

  // The sub-clock is far slower than sys_clk, so its edges are sampled.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 5'h0;
      sub_half <= 1'b0;
      samp_tick <= 1'b0;
    end else if (!running || reinit) begin
      div_cnt <= 5'h0;
      sub_half <= 1'b0;
      samp_tick <= 1'b0;
    end else if (clk_sel == DSADC_CLK_SUB2) begin
      samp_tick <= 1'b0;
      if (sub_sync[1] && !sub_prev) begin
        sub_half <= !sub_half;
        samp_tick <= sub_half;
      end
    end else begin
      samp_tick <= (div_cnt == div_last);
      div_cnt <= (div_cnt == div_last) ? 5'h0 : div_cnt + 5'h1;
    end
  end

  // Decimation filter.
  dsadc_result_t dec_result;
  logic dec_done;
  logic [4:0] log2_n;

  always_comb begin
    log2_n = log2_of_code(sample_count_sel);
  end

  dsadc_decimator u_decimator (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .restart(reinit),
    .run(running),
    .tick(samp_tick),
    .mod_bit(mod_sync[1]),
    .log2_n(log2_n),
    .result(dec_result),
    .done(dec_done)
  );

  // A control A write landing with a completion wins; the result is dropped.
  logic load_ok;
  logic load_done;

  always_comb begin
    load_ok = dec_done && running && !wr_ctla && !reinit;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_wide <= 32'h0;
      result_high_byte <= `DSADC_RST_BYTE;
    end else if (load_ok) begin
      result_wide <= {dec_result, 16'h0};
      result_high_byte <= dec_result[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_done <= 1'b0;
      conv_done_irq <= 1'b0;
    end else begin
      load_done <= load_ok;
      conv_done_irq <= load_done;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_channel_status <= `DSADC_RST_BYTE;
    end else begin
      if (dec_done && running) begin
        conv_channel_status[`DSADC_S_CHAN_HI:`DSADC_S_CHAN_LO] <= chan_sel;
      end
      if (dec_done && running && wr_ctla) begin
        conv_channel_status[`DSADC_S_COLLIDE] <= 1'b1;
      end else if (wr_status && hwdata[`DSADC_S_COLLIDE]) begin
        conv_channel_status[`DSADC_S_COLLIDE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_power_on <= 1'b0;
      ana_high_accuracy <= 1'b0;
      ana_differential <= 1'b0;
      ana_chan <= 2'h0;
      ana_parallel <= 1'b0;
      ana_sample_clk <= 1'b0;
    end else begin
      ana_power_on <= converter_power_on;
      ana_high_accuracy <= high_accuracy_en;
      ana_differential <= input_mode_sel;
      ana_chan <= chan_sel;
      ana_parallel <= serial_parallel_sel;
      ana_sample_clk <= samp_tick;
    end
  end

  // Pins owned by the running pair stop being driven as port pins one cycle after running starts.
  logic [7:0] taken;

  always_comb begin
    taken = running ? pair_mask(chan_sel) : 8'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_out <= 8'h0;
      port_oe <= 8'h0;
      port_analog <= 8'h0;
    end else begin
      port_out <= port_data;
      port_oe <= ~pin_direction_cfg & ~pin_analog_config & ~taken;
      port_analog <= pin_analog_config | taken;
    end
  end

endmodule : dsadc_ctrl

// ===== sim/dsadc_ctrl_chk.sv
// Checker for bus waits, interrupt pacing and control copies.
`timescale 1ns/10ps
`include "dsadc_defs.svh"

module dsadc_ctrl_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire dsadc_pkg::dsadc_word_t hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Converter side.
  input wire logic ana_power_on,
  input wire logic ana_high_accuracy,
  input wire logic ana_differential,
  input wire dsadc_pkg::dsadc_chan_t ana_chan,
  input wire logic ana_parallel,
  input wire logic [7:0] port_oe,
  input wire logic [7:0] port_analog,
  input wire logic conv_done_irq
);
  import dsadc_pkg::*;
  logic take;
  logic res_rd;
  logic idle;
  logic wa_q;
  logic wb_q;
  logic par_q;
  logic [7:0] ctla_q;
  logic [15:0] gap;
  assign take = hsel & htrans[1] & hready & (haddr[1:0] == 2'h0);
  assign res_rd = take & !hwrite
    & ((haddr[31:2] == {14'h0, `DSADC_IDX_RES_WIDE})
    | (haddr[31:2] == {14'h0, `DSADC_IDX_RES_HIGH}));
  assign idle = !(ctla_q[7] & ctla_q[6] & (ctla_q[1:0] != 2'h3));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wa_q <= 1'b0;
      wb_q <= 1'b0;
    end else begin
      wa_q <= take & hwrite & (haddr[31:2] == {14'h0, `DSADC_IDX_CTLA});
      wb_q <= take & hwrite & (haddr[31:2] == {14'h0, `DSADC_IDX_CTLB});
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctla_q <= 8'h00;
      par_q <= 1'b0;
    end else begin
      if (wa_q) ctla_q <= hwdata[7:0];
      if (wb_q) par_q <= hwdata[5];
    end
  end
  // Cycles since the last interrupt, saturating.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) gap <= 16'h0000;
    else if (conv_done_irq) gap <= 16'h0000;
    else if (gap != 16'hffff) gap <= gap + 16'h0001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_result_read_wait: assert property (
    res_rd |=> !hreadyout ##1 hreadyout) else $error("result read wait");
  chk_plain_no_wait: assert property (
    take & !res_rd |=> hreadyout) else $error("unexpected wait");
  chk_resp_okay: assert property (
    hresp == 1'b0) else $error("response not okay");
  chk_irq_single: assert property (
    $rose(conv_done_irq) |=> !conv_done_irq) else $error("irq too long");
  chk_irq_pacing: assert property (
    $rose(conv_done_irq) |-> gap >= 16'h03e8) else $error("irq too soon");
  chk_idle_quiet: assert property (
    idle [*4] |-> !conv_done_irq) else $error("irq while stopped");
  chk_ctla_copy: assert property (
    wa_q |=> ##[0:1] (ana_power_on == ctla_q[7]
    && ana_high_accuracy == ctla_q[5] && ana_differential == ctla_q[4]
    && ana_chan == ctla_q[1:0])) else $error("control copy wrong");
  chk_ctlb_copy: assert property (
    wb_q |=> ##[0:1] (ana_parallel == par_q)) else $error("mode copy wrong");
  chk_analog_undriven: assert property (
    (port_oe & port_analog) == 8'h00) else $error("analog pin driven");
  cov_result_read: cover property (res_rd);
  cov_irq: cover property ($rose(conv_done_irq));
  cov_ctla_write: cover property (wa_q);
endmodule : dsadc_ctrl_chk

// ===== sim/tb_top.sv
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`include "dsadc_defs.svh"

module tb_top;
  import dsadc_pkg::*;
  localparam logic [31:0] A_CA = {14'h0, `DSADC_IDX_CTLA, 2'b00};
  localparam logic [31:0] A_CB = {14'h0, `DSADC_IDX_CTLB, 2'b00};
  localparam logic [31:0] A_RW = {14'h0, `DSADC_IDX_RES_WIDE, 2'b00};
  localparam logic [31:0] A_RH = {14'h0, `DSADC_IDX_RES_HIGH, 2'b00};
  localparam logic [31:0] A_ST = {14'h0, `DSADC_IDX_STATUS, 2'b00};
  localparam logic [31:0] A_PC = {14'h0, `DSADC_IDX_PIN_CFG, 2'b00};
  localparam logic [31:0] A_PD = {14'h0, `DSADC_IDX_PIN_DIR, 2'b00};
  localparam logic [31:0] A_PT = {14'h0, `DSADC_IDX_PORT_DATA, 2'b00};
  localparam int LIMIT = 90000;
  logic sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic mod_bit_in, sub_clk_in, ana_power_on, ana_high_accuracy;
  logic ana_differential, ana_parallel, ana_sample_clk, conv_done_irq;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] port_in, port_out, port_oe, port_analog;
  dsadc_word_t hwdata, hrdata;
  dsadc_chan_t ana_chan;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int irq_cnt = 0;
  int tick_cnt = 0;
  assign hready = hreadyout;
  dsadc_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .mod_bit_in(mod_bit_in),
    .sub_clk_in(sub_clk_in), .ana_power_on(ana_power_on),
    .ana_high_accuracy(ana_high_accuracy),
    .ana_differential(ana_differential), .ana_chan(ana_chan),
    .ana_parallel(ana_parallel), .ana_sample_clk(ana_sample_clk),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
    .port_analog(port_analog), .conv_done_irq(conv_done_irq));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    // The sub-clock runs free with a period of eight system clocks.
    sub_clk_in <= cyc[2];
    if (conv_done_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (ana_sample_clk === 1'b1) tick_cnt <= tick_cnt + 1;
    if (cyc == LIMIT) begin
      fails++;
      end_of_test();
    end
  end
  task end_of_test;
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task check(input dsadc_word_t seen, input dsadc_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task xfer(input logic wr, input logic [31:0] a, input dsadc_word_t wd,
    output dsadc_word_t rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task wr(input logic [31:0] a, input dsadc_word_t d);
    dsadc_word_t x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task rc(input logic [31:0] a, input dsadc_word_t exp);
    dsadc_word_t x;
    xfer(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask : rc
  task wait_irq(output int t);
    int n0;
    n0 = irq_cnt;
    while (irq_cnt == n0) @(posedge sys_clk);
    t = cyc;
  endtask : wait_irq
  task in_range(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h1);
  endtask : in_range
  task t_reset;
    rc(A_CA, 32'h0);
    rc(A_CB, 32'h0);
    rc(A_RW, 32'h0);
    rc(A_RH, 32'h0);
    rc(A_ST, 32'h0);
    rc(A_PC, 32'h0);
    rc(A_PD, 32'hff);
  endtask : t_reset
  task t_fields;
    wr(A_CA, 32'h3f);
    rc(A_CA, 32'h33);
    check({28'h0, ana_high_accuracy, ana_differential, ana_chan}, 32'hf);
    wr(A_CB, 32'hff);
    rc(A_CB, 32'he7);
    check({31'h0, ana_parallel}, 32'h1);
    wr(A_CB, 32'h0);
    wr(A_CA, 32'h0);
    wr(32'h0004_0000, 32'hff);
    rc(32'h0004_0000, 32'h0);
  endtask : t_fields
  task t_port;
    port_in <= 8'h5a;
    wr(A_PD, 32'h0);
    wr(A_PT, 32'ha5);
    rc(A_PT, 32'h5a);
    check({16'h0, port_out, port_oe}, 32'ha5ff);
    wr(A_PC, 32'h1);
    rc(A_PC, 32'h1);
    check({24'h0, port_oe}, 32'hfe);
    check({24'h0, port_analog}, 32'h1);
    wr(A_PC, 32'h0);
  endtask : t_port
  task t_conv(input dsadc_chan_t ch, input logic mb, input logic [2:0] code,
    input logic [1:0] cs);
    int n, p, t0, t1, c0, k0;
    dsadc_word_t wide;
    n = (code == 3'h0) ? 256 : (1 << (code + 9));
    // Sub-clock mode ticks on every second sub-clock rise, 16 cycles.
    p = n * ((cs == 2'h3) ? 16 : (4 << cs));
    wide = mb ? 32'hffff0000 : 32'h0;
    mod_bit_in <= mb;
    wr(A_CB, {24'h0, cs, 3'h0, code});
    wr(A_CA, {30'h0, ch} | 32'h80);
    repeat (120) @(posedge sys_clk);
    wr(A_CA, {30'h0, ch} | 32'hc0);
    wait_irq(t0);
    k0 = tick_cnt;
    rc(A_RW, wide);
    rc(A_RH, {24'h0, wide[31:24]});
    rc(A_ST, {30'h0, ch});
    check({24'h0, port_oe}, {24'h0, ~(8'h03 << (2 * ch))});
    check({24'h0, port_analog}, {24'h0, 8'h03 << (2 * ch)});
    wait_irq(t1);
    in_range(t1 - t0, p - 16, p + 24);
    check(32'(tick_cnt - k0), 32'(n));
    // The rewrite lands in the very cycle of the next completion.
    repeat (p - 6) @(posedge sys_clk);
    wr(A_CA, {30'h0, ch} | 32'hc0);
    c0 = cyc;
    wait_irq(t1);
    in_range(t1 - c0, p - 16, p + 24);
    rc(A_ST, {27'h0, 1'b1, 2'h0, ch});
    wr(A_ST, 32'h10);
    rc(A_ST, {30'h0, ch});
    wr(A_CA, {30'h0, ch} | 32'h80);
    mod_bit_in <= ~mb;
    c0 = irq_cnt;
    repeat (p + 100) @(posedge sys_clk);
    check(32'(irq_cnt), 32'(c0));
    rc(A_RW, wide);
    wr(A_CA, 32'h0);
  endtask : t_conv
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mod_bit_in = 1'b0;
    port_in = 8'h00;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_port();
    t_conv(2'h0, 1'b1, 3'h0, 2'h1);
    t_conv(2'h2, 1'b0, 3'h1, 2'h0);
    t_conv(2'h1, 1'b1, 3'h0, 2'h3);
    t_conv(2'h0, 1'b0, 3'h0, 2'h2);
    end_of_test();
  end
endmodule : tb_top

bind dsadc_ctrl dsadc_ctrl_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .ana_power_on(ana_power_on), .ana_high_accuracy(ana_high_accuracy),
  .ana_differential(ana_differential), .ana_chan(ana_chan),
  .ana_parallel(ana_parallel), .port_oe(port_oe),
  .port_analog(port_analog), .conv_done_irq(conv_done_irq));
